// file: rsa_defs.vh
`ifndef RSA_DEFS_VH
`define RSA_DEFS_VH
// Register offsets
`define RSA_ADDR_BACKUP 8'h24
`define RSA_ADDR_LDOSW 8'h25
// Reset values
`define RSA_RST_BACKUP 8'h12
`define RSA_RST_LDOSW 8'ha7
// Writable bits of the backup slot register
`define RSA_MASK_BACKUP 8'h33
// Strobe numbering
`define RSA_STB_FIRST 4'h1
`define RSA_STB_SECOND 4'h2
`define RSA_STB_MAIN_LO 4'h3
`define RSA_STB_PRE_LAST 4'h9
`define RSA_STB_LAST 4'ha
// Timing
`define RSA_CLK_MHZ 25'h0fa
`define RSA_GAP_US 25'h7d0
`define RSA_LATE_STROBE_DELAY_SEL_SHORT_US 25'h7d0
`define RSA_LATE_STROBE_DELAY_SEL_LONG_US 25'h1388
`define RSA_DN_FACTOR 25'h00a
// Sequencer states
`define RSA_ST_IDLE 2'h0
`define RSA_ST_UP 2'h1
`define RSA_ST_DN 2'h2
`endif

// file: rsa_rail_en.v
`timescale 1ns/10ps
`include "rsa_defs.vh"
// One rail enable, driven at its assigned strobe
module rsa_rail_en #(
  parameter [3:0] LO = 4'h3,
  parameter [3:0] HI = 4'ha
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Slot field and strobe events
  input wire [3:0] field_in,
  input wire [3:0] strobe_in,
  input wire up_stb_in,
  input wire dn_stb_in,
  input wire keep_on_in,
  // Rail control
  output reg en_out,
  output reg ctl_out
);
  wire in_range;
  wire hit;

  // Field selects a valid strobe
  assign in_range = (field_in >= LO) && (field_in <= HI);
  assign hit = in_range && (field_in == strobe_in);

  // Enable set on power-up, cleared on power-down unless keep_on_in is high
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      en_out <= 1'b0;
      ctl_out <= 1'b0;
    end else begin
      ctl_out <= in_range;
      if (up_stb_in && hit) begin
        en_out <= 1'b1;
      end else if (dn_stb_in && hit && !keep_on_in) begin
        en_out <= 1'b0;
      end
    end
  end
endmodule // rsa_rail_en

// file: rsa_seq.v
// Contract
// (RULE_01) Backup slot register at 0x24, reset 0x12.
// (RULE_02) LDO and switch slot register at 0x25, reset 0xa7.
// (RULE_03) Backup field 1h enables at strobe 1, 2h at strobe 2.
// (RULE_04) Backup field 0h or 3h: converter enable never driven.
// (RULE_05) Strobes 1 and 2 run only while seal flag reads 0.
// (RULE_06) Once seal broken, backup converters are never disabled.
// (RULE_07) Rail field 3h to Ah enables rail at strobe 3 to 10.
// (RULE_08) Rail field 0h-2h or Bh-Fh leaves rail uncontrolled.
// (RULE_09) Delay between strobes 9 and 10 is 2 ms or 5 ms.
// (RULE_10) Power-down delay multiplier makes power-down gaps ten times.
// (RULE_11) Power-up steps ascending enabling; power-down descending disabling.
// (RULE_12) Reserved bit pairs of backup register read zero, ignore writes.
`timescale 1ns/10ps
`include "rsa_defs.vh"
module rsa_seq #(
  parameter [24:0] GAP_CYC = `RSA_GAP_US * `RSA_CLK_MHZ,
  parameter [24:0] LATE_STROBE_DELAY_SEL_SHORT_CYC = `RSA_LATE_STROBE_DELAY_SEL_SHORT_US * `RSA_CLK_MHZ,
  parameter [24:0] LATE_STROBE_DELAY_SEL_LONG_CYC = `RSA_LATE_STROBE_DELAY_SEL_LONG_US * `RSA_CLK_MHZ
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Register access from host port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // Sequencer control
  input wire pwr_up_req_in,
  input wire pwr_dn_req_in,
  input wire freshness_seal_flag_in,
  input wire late_strobe_delay_sel_in,
  input wire powerdown_delay_multiplier_in,
  // Sequencer status
  output reg seq_busy_out,
  output reg [3:0] strobe_out,
  // Rail enables and control flags
  output wire backup_converter_a_en_out,
  output wire backup_converter_b_en_out,
  output wire low_voltage_load_switch_en_out,
  output wire general_linear_regulator_en_out,
  output wire backup_converter_a_ctl_out,
  output wire backup_converter_b_ctl_out,
  output wire low_voltage_load_switch_ctl_out,
  output wire general_linear_regulator_ctl_out
);
  reg [7:0] backup_slot_r;
  reg [7:0] ldosw_slot_r;
  reg [1:0] state_r;
  reg [3:0] strb_r;
  reg [24:0] cnt_r;
  reg stb_up_r;
  reg stb_dn_r;
  reg [3:0] stb_num_r;
  reg [24:0] gap_nxt;
  wire [1:0] backup_conv_a_slot;
  wire [1:0] backup_conv_b_slot;
  wire [3:0] low_volt_switch_slot;
  wire [3:0] linear_reg_slot;
  wire last_up;
  wire last_dn;
  wire late_gap;
  wire keep_backup;

  assign backup_conv_a_slot = backup_slot_r[1:0];
  assign backup_conv_b_slot = backup_slot_r[5:4];
  assign low_volt_switch_slot = ldosw_slot_r[7:4];
  assign linear_reg_slot = ldosw_slot_r[3:0];

  // Register writes, reserved pairs held at zero
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      backup_slot_r <= `RSA_RST_BACKUP; // see RULE_01
      ldosw_slot_r <= `RSA_RST_LDOSW; // see RULE_02
    end else if (reg_wr_in) begin
      if (reg_addr_in == `RSA_ADDR_BACKUP) begin
        backup_slot_r <= reg_wdata_in & `RSA_MASK_BACKUP; // see RULE_12
      end
      if (reg_addr_in == `RSA_ADDR_LDOSW) begin
        ldosw_slot_r <= reg_wdata_in;
      end
    end
  end

  // Registered read data, unmapped reads return zero
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `RSA_ADDR_BACKUP: reg_rdata_out <= backup_slot_r; // see RULE_01
        `RSA_ADDR_LDOSW: reg_rdata_out <= ldosw_slot_r; // see RULE_02
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // End of sequence, seal skips the backup strobes
  assign last_up = (strb_r == `RSA_STB_LAST);
  assign last_dn = freshness_seal_flag_in ?
    (strb_r == `RSA_STB_MAIN_LO) : (strb_r == `RSA_STB_FIRST); // see RULE_05
  assign late_gap = (state_r == `RSA_ST_UP) ?
    (strb_r == `RSA_STB_PRE_LAST) : (strb_r == `RSA_STB_LAST);

  // Gap to the next strobe
  always @* begin
    gap_nxt = late_gap ?
      (late_strobe_delay_sel_in ? LATE_STROBE_DELAY_SEL_LONG_CYC : LATE_STROBE_DELAY_SEL_SHORT_CYC) :
      GAP_CYC; // see RULE_09
    if (state_r == `RSA_ST_DN && powerdown_delay_multiplier_in) begin
      gap_nxt = gap_nxt * `RSA_DN_FACTOR; // see RULE_10
    end
  end

  // Strobe stepping state machine
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= `RSA_ST_IDLE;
      strb_r <= `RSA_STB_FIRST;
      cnt_r <= 25'h0000000;
      stb_up_r <= 1'b0;
      stb_dn_r <= 1'b0;
      stb_num_r <= 4'h0;
      seq_busy_out <= 1'b0;
      strobe_out <= 4'h0;
    end else begin
      stb_up_r <= 1'b0;
      stb_dn_r <= 1'b0;
      case (state_r)
        `RSA_ST_IDLE: begin
          seq_busy_out <= 1'b0;
          cnt_r <= 25'h0000000;
          if (pwr_up_req_in) begin
            state_r <= `RSA_ST_UP;
            seq_busy_out <= 1'b1;
            strb_r <= freshness_seal_flag_in ?
              `RSA_STB_MAIN_LO : `RSA_STB_FIRST; // see RULE_05
          end else if (pwr_dn_req_in) begin
            state_r <= `RSA_ST_DN;
            seq_busy_out <= 1'b1;
            strb_r <= `RSA_STB_LAST;
          end
        end
        `RSA_ST_UP, `RSA_ST_DN: begin
          if (cnt_r != 25'h0000000) begin
            cnt_r <= cnt_r - 25'h0000001;
          end else begin
            stb_up_r <= (state_r == `RSA_ST_UP); // see RULE_11
            stb_dn_r <= (state_r == `RSA_ST_DN); // see RULE_11
            stb_num_r <= strb_r;
            strobe_out <= strb_r;
            if ((state_r == `RSA_ST_UP) ? last_up : last_dn) begin
              state_r <= `RSA_ST_IDLE;
            end else begin
              cnt_r <= gap_nxt;
              strb_r <= (state_r == `RSA_ST_UP) ?
                strb_r + 4'h1 : strb_r - 4'h1; // see RULE_11
            end
          end
        end
        default: begin
          state_r <= `RSA_ST_IDLE;
        end
      endcase
    end
  end

  // Backup converters stay on once seal is broken
  assign keep_backup = freshness_seal_flag_in; // see RULE_06

  // Backup converters use strobes 1 and 2 only
  rsa_rail_en #(.LO(`RSA_STB_FIRST), .HI(`RSA_STB_SECOND)) u_conv_a (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .field_in({2'b00, backup_conv_a_slot}), // see RULE_03
    .strobe_in(stb_num_r),
    .up_stb_in(stb_up_r),
    .dn_stb_in(stb_dn_r),
    .keep_on_in(keep_backup), // see RULE_06
    .en_out(backup_converter_a_en_out),
    .ctl_out(backup_converter_a_ctl_out) // see RULE_04
  );
  rsa_rail_en #(.LO(`RSA_STB_FIRST), .HI(`RSA_STB_SECOND)) u_conv_b (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .field_in({2'b00, backup_conv_b_slot}), // see RULE_03
    .strobe_in(stb_num_r),
    .up_stb_in(stb_up_r),
    .dn_stb_in(stb_dn_r),
    .keep_on_in(keep_backup), // see RULE_06
    .en_out(backup_converter_b_en_out),
    .ctl_out(backup_converter_b_ctl_out) // see RULE_04
  );

  // Load switch and LDO use strobes 3 to 10
  rsa_rail_en #(.LO(`RSA_STB_MAIN_LO), .HI(`RSA_STB_LAST)) u_switch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .field_in(low_volt_switch_slot), // see RULE_07
    .strobe_in(stb_num_r),
    .up_stb_in(stb_up_r),
    .dn_stb_in(stb_dn_r),
    .keep_on_in(1'b0),
    .en_out(low_voltage_load_switch_en_out),
    .ctl_out(low_voltage_load_switch_ctl_out) // see RULE_08
  );
  rsa_rail_en #(.LO(`RSA_STB_MAIN_LO), .HI(`RSA_STB_LAST)) u_ldo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .field_in(linear_reg_slot), // see RULE_07
    .strobe_in(stb_num_r),
    .up_stb_in(stb_up_r),
    .dn_stb_in(stb_dn_r),
    .keep_on_in(1'b0),
    .en_out(general_linear_regulator_en_out),
    .ctl_out(general_linear_regulator_ctl_out) // see RULE_08
  );
endmodule // rsa_seq

// file: rsa_seq_sva.sv
`timescale 1ns/10ps
module rsa_seq_sva (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Register read side
  input wire [7:0] reg_addr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // Sequencer side
  input wire freshness_seal_flag_in,
  input wire [3:0] strobe_out,
  input wire backup_converter_a_en_out,
  input wire backup_converter_b_en_out,
  input wire general_linear_regulator_en_out,
  input wire low_voltage_load_switch_en_out,
  input wire backup_converter_b_ctl_out,
  input wire low_voltage_load_switch_ctl_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // Strobe number held through a gap
  sequence hold_two;
    $stable(strobe_out) [*2];
  endsequence
  // Output relations
  rsvd_zero_a: assert property (
    reg_rd_in && reg_addr_in == 8'h24 |=> reg_rdata_out[7:6] == 2'h0
    && reg_rdata_out[3:2] == 2'h0) else $error("reserved bits set");
  seal_skip_a: assert property (
    freshness_seal_flag_in && $changed(strobe_out) |-> strobe_out > 4'h2)
    else $error("strobe 1 or 2 with seal broken");
  seal_hold_a: assert property (
    freshness_seal_flag_in && $past(freshness_seal_flag_in) |->
    !$fell(backup_converter_a_en_out) && !$fell(backup_converter_b_en_out))
    else $error("backup rail disabled after seal");
  bk_slot_a: assert property (
    $rose(backup_converter_a_en_out) |-> strobe_out inside {4'h1, 4'h2})
    else $error("backup rail on at wrong strobe");
  rail_slot_a: assert property (
    $rose(general_linear_regulator_en_out) |->
    strobe_out inside {[4'h3:4'ha]}) else $error("rail on at wrong strobe");
  bk_free_a: assert property (
    !backup_converter_b_ctl_out && !$past(backup_converter_b_ctl_out) |->
    $stable(backup_converter_b_en_out)) else $error("free backup driven");
  sw_free_a: assert property (
    !low_voltage_load_switch_ctl_out && !$past(low_voltage_load_switch_ctl_out)
    |-> $stable(low_voltage_load_switch_en_out)) else $error("free rail moved");
  gap_hold_a: assert property (
    $changed(strobe_out) |=> hold_two) else $error("strobe gap too short");
endmodule // rsa_seq_sva
bind rsa_seq rsa_seq_sva i_sva (.*);

// file: rsa_rail_model.sv
`timescale 1ns/10ps
// Rail enable inputs: log strobe of each turn-on and turn-off
module rsa_rail_model (
  // Clock
  input wire clk_sys_in,
  // Enables and strobe seen by the rails
  input wire [3:0] en_in,
  input wire [3:0] strobe_in,
  // Strobe log, one nibble per rail
  output reg [15:0] on_at_out = 16'h0,
  output reg [15:0] off_at_out = 16'h0
);
  reg [3:0] last_r = 4'h0;
  integer i;
  // Record strobe number on each enable edge
  always @(posedge clk_sys_in) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (en_in[i] && !last_r[i]) on_at_out[4*i +: 4] <= strobe_in;
      if (!en_in[i] && last_r[i]) off_at_out[4*i +: 4] <= strobe_in;
    end
    last_r <= en_in;
  end
endmodule // rsa_rail_model

// file: rail_strobe_assignment_tb_top.sv
`timescale 1ns/10ps
module rail_strobe_assignment_tb_top;
  // Design inputs
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic pwr_up_req_in = 1'b0, pwr_dn_req_in = 1'b0;
  logic freshness_seal_flag_in = 1'b0, late_strobe_delay_sel_in = 1'b0;
  logic powerdown_delay_multiplier_in = 1'b0;
  // Design outputs
  wire [7:0] reg_rdata_out;
  wire [3:0] strobe_out;
  wire seq_busy_out, backup_converter_a_en_out, backup_converter_b_en_out;
  wire low_voltage_load_switch_en_out, general_linear_regulator_en_out;
  wire backup_converter_a_ctl_out, backup_converter_b_ctl_out;
  wire low_voltage_load_switch_ctl_out, general_linear_regulator_ctl_out;
  wire [3:0] en = {low_voltage_load_switch_en_out,
    general_linear_regulator_en_out, backup_converter_b_en_out,
    backup_converter_a_en_out};
  wire [3:0] ctl = {low_voltage_load_switch_ctl_out,
    general_linear_regulator_ctl_out, backup_converter_b_ctl_out,
    backup_converter_a_ctl_out};
  wire [15:0] on_at, off_at;
  int miscompares = 0, num_checks = 0, cyc = 0, ticks = 0;
  // Short gaps: 3 cycles, strobe 9 to 10 four or six
  rsa_seq #(.GAP_CYC(25'd2), .LATE_STROBE_DELAY_SEL_SHORT_CYC(25'd3), .LATE_STROBE_DELAY_SEL_LONG_CYC(25'd5))
    i_dut (.*);
  rsa_rail_model i_rails (.clk_sys_in(clk_sys_in), .en_in(en),
    .strobe_in(strobe_out), .on_at_out(on_at), .off_at_out(off_at));
  always #2 clk_sys_in = ~clk_sys_in;
  // Cut a hang short
  always @(posedge clk_sys_in) begin
    ticks <= ticks + 1;
    if (ticks == 3000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk({8'h00, reg_rdata_out}, {8'h00, exp});
  endtask
  // Request a sequence with seal, delay select, multiplier; count busy
  task seq(input up, input s, input l, input m);
    @(posedge clk_sys_in);
    pwr_up_req_in <= up;
    pwr_dn_req_in <= !up;
    freshness_seal_flag_in <= s;
    late_strobe_delay_sel_in <= l;
    powerdown_delay_multiplier_in <= m;
    @(posedge clk_sys_in);
    pwr_up_req_in <= 1'b0;
    pwr_dn_req_in <= 1'b0;
    cyc = 0;
    #1;
    while (seq_busy_out === 1'b1) begin
      cyc = cyc + 1;
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
    #1;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    wr(8'h26, 8'h55);
    rd(8'h24, 8'h12);
    rd(8'h25, 8'ha7);
    rd(8'h26, 8'h00);
    wr(8'h24, 8'hff);
    rd(8'h24, 8'h33);
    chk({12'h0, ctl}, 16'hc);
    wr(8'h24, 8'h12);
    seq(1, 0, 0, 0);
    chk(cyc[15:0], 16'd30);
    chk(on_at, 16'ha712);
    seq(0, 0, 0, 0);
    chk(off_at, 16'ha712);
    seq(1, 0, 1, 0);
    chk(cyc[15:0], 16'd32);
    seq(0, 0, 1, 1);
    chk({15'h0, cyc > 150}, 16'h1);
    wr(8'h24, 8'h30);
    wr(8'h25, 8'hb3);
    seq(1, 0, 0, 0);
    chk({12'h0, en}, 16'h4);
    chk({12'h0, ctl}, 16'h4);
    seq(0, 0, 0, 0);
    wr(8'h24, 8'h12);
    wr(8'h25, 8'ha7);
    seq(1, 0, 0, 0);
    seq(0, 1, 0, 0);
    chk({12'h0, en}, 16'h3);
    seq(1, 1, 0, 0);
    chk(cyc[15:0], 16'd24);
    summarize;
  end
endmodule // rail_strobe_assignment_tb_top
